// ### dv/ccg_clock_gen_tb.sv
// Self-checking bench for the clock generation block.
`timescale 1ns/1ps
`include "ccg_consts.svh"
module ccg_clock_gen_tb;
import ccg_pkg::*;
logic        pclk = 1'b0;
logic        presetn = 1'b0;
logic        psel = 1'b0;
logic        penable = 1'b0;
logic        pwrite = 1'b0;
logic [7:0]  paddr = 8'h00;
logic [31:0] pwdata = 32'h0;
logic        wake_pin = 1'b0;
logic [31:0] prdata, rdat;
logic        pready, pslverr, err, ref_clk, buf_out, pin_out, core_clock, system_clock, pll_locked;
ccg_mode_e   op_mode;
int          phy_edges, failures = 0, n_tests = 0, cyc = 0, ref_edges = 0;
////////////////////////////////////////////////////////////////////////////////
ccg_clock_gen #(.LOCK_CYCLES(16'h0008)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .input_reference_clock(ref_clk), .wake_pin(wake_pin), .buffered_clock_out(buf_out),
    .system_clock_out_pin(pin_out), .core_clock(core_clock), .system_clock(system_clock),
    .pll_locked(pll_locked), .op_mode(op_mode));
ccg_ref_osc i_osc (.clk_ref(ref_clk), .phy_clk_in(buf_out), .phy_edges(phy_edges));
always #25 pclk = ~pclk;
always @(posedge ref_clk) ref_edges++;
always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
        failures++;
        results();
    end
end
////////////////////////////////////////////////////////////////////////////////
task automatic results;
    if (failures == 0 && n_tests > 0) begin
        $display("bench passed");
    end else begin
        $display("bench failed");
    end
    $finish;
endtask
task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
        failures++;
        $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
endtask
task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
        n++;
        @(posedge pclk);
    end
    chk("apb_wait", 32'h0, n);
    rdat = prdata;
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
endtask
task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rdat);
endtask
task automatic lock_low(output int low);
    int t;
    t = 0;
    low = 0;
    while (pll_locked === 1'b1 && t < 10) begin @(posedge pclk); t++; end
    while (pll_locked !== 1'b1 && low < 100) begin @(posedge pclk); low++; end
endtask
// Measures one system clock half period and the core toggles inside it.
task automatic half(output int n, output int hp);
    logic s, c;
    s = system_clock;
    hp = 0;
    while (system_clock === s && hp < 400) begin @(posedge pclk); hp++; end
    s = system_clock;
    c = core_clock;
    n = 0;
    hp = 0;
    while (system_clock === s && hp < 400) begin
        @(posedge pclk);
        hp++;
        n += (core_clock !== c);
        c = core_clock;
    end
endtask
////////////////////////////////////////////////////////////////////////////////
task automatic t_reset;
    rdchk("pll_ctrl", `CCG_OFF_PLL_CTRL, 32'h0000000A);
    rdchk("clk_div", `CCG_OFF_CLK_DIV, 32'h00000005);
    rdchk("reg_ctrl", `CCG_OFF_REG_CTRL, 32'h00000001);
    rdchk("sdram_ctl", `CCG_OFF_SDRAM_GCTL, 32'h00000001);
    rdchk("async_ctl", `CCG_OFF_ASYNC_GCTL, 32'h00000001);
    apb(1'b1, `CCG_OFF_STATUS, 32'h00000000);
    rdchk("status", `CCG_OFF_STATUS, 32'h0000008A);
    rdchk("unmapped", 8'h18, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
endtask
task automatic t_buf;
    int r, p;
    r = ref_edges;
    p = phy_edges;
    repeat (100) @(posedge pclk);
    chk("buf_edges", 32'h1, 32'(((ref_edges - r) - (phy_edges - p)) inside {[-1:1]}));
    apb(1'b1, `CCG_OFF_REG_CTRL, 32'h0);
    repeat (5) @(posedge pclk);
    p = phy_edges;
    repeat (100) @(posedge pclk);
    chk("buf_stopped", p, phy_edges);
    apb(1'b1, `CCG_OFF_REG_CTRL, 32'h1);
    p = phy_edges;
    repeat (100) @(posedge pclk);
    chk("buf_again", 32'h1, 32'(phy_edges - p > 20));
endtask
task automatic t_relock;
    logic [5:0] m [2] = '{6'h00, 6'h14};
    int low;
    apb(1'b1, `CCG_OFF_PLL_CTRL, 32'h00000003);
    rdchk("no_apply", `CCG_OFF_STATUS, 32'h0000008A);
    foreach (m[i]) begin
        apb(1'b1, `CCG_OFF_PLL_CTRL, 32'h00000400 | {26'h0, m[i]});
        lock_low(low);
        chk("lock_low", 32'h8, low);
        rdchk("status_msel", `CCG_OFF_STATUS, 32'h00000080 | {26'h0, m[i]});
    end
endtask
task automatic t_ratio;
    logic [3:0] ss [6] = '{4'h1, 4'h4, 4'h8, 4'hC, 4'hF, 4'h4};
    logic [1:0] cs [6] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h0, 2'h0};
    int n, hp;
    foreach (ss[i]) begin
        apb(1'b1, `CCG_OFF_CLK_DIV, {26'h0, cs[i], ss[i]});
        // Three halves, so that both dividers have taken their new ratios before the measured one.
        repeat (3) half(n, hp);
        chk("core_per_sys", ss[i] >> cs[i], n);
        chk("no_relock", 32'h1, {31'h0, pll_locked});
    end
    apb(1'b1, `CCG_OFF_CLK_DIV, 32'h00000000);
    half(n, hp);
    half(n, hp);
    chk("zero_ssel", 32'h4, n);
    apb(1'b1, `CCG_OFF_CLK_DIV, 32'h00000002);
    repeat (4) begin
        half(n, hp);
        chk("min_half", 32'h1, 32'(hp >= 6));
    end
    chk("new_ratio", 32'h2, n);
endtask
task automatic t_bypass;
    int n, hp, low;
    logic sv;
    apb(1'b1, `CCG_OFF_PLL_CTRL, 32'h0000049E);
    rdchk("byp_status", `CCG_OFF_STATUS, 32'h00000194);
    chk("byp_mode", {30'h0, CCG_ACTIVE}, {30'h0, op_mode});
    half(n, hp);
    half(n, hp);
    chk("byp_ratio", 32'h1, n);
    chk("byp_half", 32'h1, 32'(hp inside {[3:4]}));
    apb(1'b1, `CCG_OFF_PLL_CTRL, 32'h0000041E);
    lock_low(low);
    chk("relock", 32'h8, low);
    rdchk("full_status", `CCG_OFF_STATUS, 32'h0000009E);
    // A stopped PLL outside bypass gives the dividers no ticks at all.
    apb(1'b1, `CCG_OFF_PLL_CTRL, 32'h0000011E);
    repeat (2) @(posedge pclk);
    chk("off_mode", {30'h0, CCG_PLL_OFF}, {30'h0, op_mode});
    sv = system_clock;
    n = 0;
    repeat (40) begin
        @(posedge pclk);
        n += (system_clock !== sv);
    end
    chk("off_stopped", 32'h0, n);
endtask
task automatic t_sleep;
    logic [31:0] w [2] = '{32'h0000021E, 32'h0000029E};
    ccg_mode_e   e [2] = '{CCG_FULL_ON, CCG_ACTIVE};
    int          k [2] = '{2, 1};
    int n, hp, t;
    foreach (w[i]) begin
        apb(1'b1, `CCG_OFF_PLL_CTRL, w[i]);
        repeat (2) @(posedge pclk);
        chk("sleep_mode", {30'h0, CCG_SLEEP}, {30'h0, op_mode});
        half(n, hp);
        half(n, hp);
        chk("core_gated", 32'h0, n);
        chk("sys_runs", 32'h1, 32'(hp < 400));
        wake_pin <= 1'b1;
        t = 0;
        while (op_mode === CCG_SLEEP && t < 20) begin @(posedge pclk); t++; end
        wake_pin <= 1'b0;
        chk("wake_mode", {30'h0, e[i]}, {30'h0, op_mode});
        half(n, hp);
        half(n, hp);
        chk("core_back", k[i], n);
    end
endtask
task automatic t_pin;
    logic [7:0] a [2] = '{`CCG_OFF_SDRAM_GCTL, `CCG_OFF_ASYNC_GCTL};
    int n;
    foreach (a[i]) begin
        apb(1'b1, a[i], 32'h0);
        repeat (3) @(posedge pclk);
        n = 0;
        repeat (40) begin @(posedge pclk); n += (pin_out !== 1'b0); end
        chk("pin_off", 32'h0, n);
        apb(1'b1, a[i], 32'h1);
        @(posedge pclk);
        n = 0;
        // Pin and system clock are registered from one divider output, so they match cycle by cycle.
        repeat (40) begin
            @(posedge pclk);
            n += (pin_out !== system_clock);
        end
        chk("pin_follows", 32'h0, n);
    end
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("locked_reset", 32'h1, {31'h0, pll_locked});
    t_reset();
    t_buf();
    t_relock();
    t_ratio();
    t_bypass();
    t_sleep();
    t_pin();
    results();
end
endmodule // ccg_clock_gen_tb

// ### dv/ccg_ref_osc.sv
// Model of the external reference oscillator and of the PHY clock input it feeds.
`timescale 1ns/1ps
module ccg_ref_osc #(
    parameter int HALF_NS = 85       // Half period, unrelated in phase and rate to the block clock.
) (
    output logic      clk_ref,       // Reference clock to the block.
    input  wire logic phy_clk_in,    // Buffered copy arriving at the PHY.
    output int        phy_edges      // Rising edges seen by the PHY.
);
    initial clk_ref = 1'b0;
    initial phy_edges = 0;
    // The source runs free and never halts or changes rate.
    always #HALF_NS clk_ref = ~clk_ref;
    always @(posedge phy_clk_in) phy_edges++;
endmodule // ccg_ref_osc

// ### rtl/ccg_clock_gen.sv
// Clock generation and distribution top with APB registers.
// Function
// [R1] Buffered clock pin copies input reference clock.
// [R2] Buffered clock on at reset, software may stop.
// [R3] Core and system clocks derived from reference; code does so only in bypass, else from the pclk-stepped VCO accumulator.
// [R4] PLL multiplies by 0.5x to 64x.
// [R5] Multiplier resets 10x, changes only via sequence.
// [R6] Divide register write changes clocks without relock.
// [R7] Divide settings keep derived clocks within limits.
// [R8] System pin follows system clock, two disables.
// [R9] Four-bit select field sets system divide ratio.
// [R10] Bypass runs clocks at input; multiplier deferred.
// [R11] Sleep stops core clock; wake follows bypass.
// [R12] Zero system select keeps previous ratio.
// [R13] Divider changes glitch-free at clock boundary.
`timescale 1ns/1ps
`include "ccg_consts.svh"
module ccg_clock_gen #(
    parameter logic [15:0] LOCK_CYCLES   = `CCG_LOCK_CYCLES,
    parameter logic [3:0]  SYS_RATIO_MIN = `CCG_SYS_RATIO_MIN
) (
    input  wire logic            pclk,                  // 20 MHz block clock.
    input  wire logic            presetn,               // Asynchronous reset, active low.
    input  wire logic            psel,                  // APB select.
    input  wire logic            penable,               // APB enable.
    input  wire logic            pwrite,                // APB write.
    input  wire logic [7:0]      paddr,                 // APB byte address.
    input  wire logic [31:0]     pwdata,                // APB write data.
    output logic [31:0]          prdata,                // APB read data.
    output logic                 pready,                // APB ready.
    output logic                 pslverr,               // APB error for unmapped address.
    input  wire logic            input_reference_clock, // Reference clock pin.
    input  wire logic            wake_pin,              // Wake-up event from sleep.
    output logic                 buffered_clock_out,    // Buffered reference for the PHY.
    output logic                 system_clock_out_pin,  // System clock to the pin.
    output logic                 core_clock,            // Derived core clock.
    output logic                 system_clock,          // Derived system clock.
    output logic                 pll_locked,            // PLL settled on its multiplier.
    output ccg_pkg::ccg_mode_e   op_mode                // Current operating mode.
);
    import ccg_pkg::*;

    ccg_state_s s, n;
    logic       vco_tick, ref_rise, core_div_clk, sys_div_clk;
    logic [3:0] core_ratio, sys_ratio;
    logic [7:0] vco_sum;
    logic [7:0] half_mult;

    ////////////////////////////////////////////////////////////////////////////////
    // Register decode.

    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == `CCG_OFF_PLL_CTRL) || (a == `CCG_OFF_CLK_DIV) || (a == `CCG_OFF_REG_CTRL) ||
                   (a == `CCG_OFF_SDRAM_GCTL) || (a == `CCG_OFF_ASYNC_GCTL) || (a == `CCG_OFF_STATUS);
    endfunction

    function automatic logic [31:0] rd_word(input logic [7:0] a, input ccg_state_s st);
        rd_word = 32'h0000_0000;
        unique case (a)
            `CCG_OFF_PLL_CTRL:   rd_word = {21'h0, st.relock_req, st.sleep, st.pll_off, st.bypass,
                                             st.pend_df, st.pend_msel};
            `CCG_OFF_CLK_DIV:    rd_word = {26'h0, st.csel, st.ssel};
            `CCG_OFF_REG_CTRL:   rd_word = {31'h0, st.buf_en};
            `CCG_OFF_SDRAM_GCTL: rd_word = {31'h0, st.sd_en};
            `CCG_OFF_ASYNC_GCTL: rd_word = {31'h0, st.am_en};
            `CCG_OFF_STATUS:     rd_word = {22'h0, st.mode, st.locked, st.act_df, st.act_msel};
            default:             rd_word = 32'h0000_0000;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // VCO model: a phase accumulator advances by the multiplier in half steps.

    always_comb begin
        if (s.act_msel == 6'h0) begin
            half_mult = `CCG_VCO_FULL; // [R4]
        end else if (s.act_df) begin
            half_mult = {2'b00, s.act_msel};
        end else begin
            half_mult = {1'b0, s.act_msel, 1'b0};
        end
        vco_sum  = {1'b0, s.vco_acc} + half_mult;
        ref_rise = s.ref_s2 && !s.ref_s3;
        // Bypass feeds the dividers straight from the reference clock.
        vco_tick = s.bypass ? ref_rise : (!s.pll_off && s.locked && vco_sum[7]); // [R3] [R10]
        core_ratio = s.bypass ? 4'h1 : (4'h1 << s.csel); // [R10]
        sys_ratio  = s.bypass ? 4'h1 : s.ssel; // [R9] [R10]
    end

    ccg_divider u_core_div (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (vco_tick),
        .run     (!s.sleep),
        .ratio   (core_ratio),
        .clk_out (core_div_clk),
        .pulse   ()
    );

    ccg_divider u_sys_div (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (vco_tick),
        .run     (1'b1),
        .ratio   (sys_ratio),
        .clk_out (sys_div_clk),
        .pulse   ()
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        logic       wr;
        logic [3:0] new_ssel;
        wr       = psel && penable && pwrite && s.pready;
        new_ssel = pwdata[`CCG_DIV_SSEL_LSB +: 4];
        n = s;
        n.ref_s1  = input_reference_clock;
        n.ref_s2  = s.ref_s1;
        n.ref_s3  = s.ref_s2;
        n.wake_s1 = wake_pin;
        n.wake_s2 = s.wake_s1;
        n.wake_s3 = s.wake_s2;
        n.pready  = 1'b1;
        if (psel && !penable) begin
            n.pslverr = !addr_hit(paddr);
            n.prdata  = rd_word(paddr, s);
        end
        if (!s.bypass) begin
            n.vco_acc = vco_sum[6:0];
        end
        // Relock: the pending multiplier reaches the VCO only outside bypass.
        if (s.lock_cnt != 16'h0) begin
            n.lock_cnt = s.lock_cnt - 16'h1;
            n.locked   = (s.lock_cnt == 16'h1);
        end else if (s.relock_req && !s.bypass && !s.pll_off) begin
            n.act_msel   = s.pend_msel; // [R5] [R10]
            n.act_df     = s.pend_df;
            n.relock_req = 1'b0;
            n.locked     = 1'b0;
            n.lock_cnt   = LOCK_CYCLES;
        end
        if (s.wake_s2 && !s.wake_s3) begin
            n.sleep = 1'b0; // [R11]
        end
        if (wr) begin
            unique case (paddr)
                `CCG_OFF_PLL_CTRL: begin
                    n.pend_msel = pwdata[`CCG_PLL_MSEL_LSB +: 6]; // [R5]
                    n.pend_df   = pwdata[`CCG_PLL_DF_BIT];
                    n.bypass    = pwdata[`CCG_PLL_BYPASS_BIT];
                    n.pll_off   = pwdata[`CCG_PLL_OFF_BIT];
                    n.sleep     = pwdata[`CCG_PLL_SLEEP_BIT]; // [R11]
                    if (pwdata[`CCG_PLL_APPLY_BIT]) begin
                        n.relock_req = 1'b1; // [R5]
                    end
                end
                `CCG_OFF_CLK_DIV: begin
                    n.csel = pwdata[`CCG_DIV_CSEL_LSB +: 2]; // [R6]
                    if (new_ssel == 4'h0) begin
                        n.ssel = s.ssel; // [R12]
                    end else if (new_ssel < SYS_RATIO_MIN) begin
                        n.ssel = SYS_RATIO_MIN; // [R7]
                    end else begin
                        n.ssel = new_ssel; // [R6] [R9]
                    end
                end
                `CCG_OFF_REG_CTRL:   n.buf_en = pwdata[`CCG_ENABLE_BIT]; // [R2]
                `CCG_OFF_SDRAM_GCTL: n.sd_en  = pwdata[`CCG_ENABLE_BIT]; // [R8]
                `CCG_OFF_ASYNC_GCTL: n.am_en  = pwdata[`CCG_ENABLE_BIT]; // [R8]
                default: ;
            endcase
        end
        if (s.pll_off && !s.bypass) begin
            n.mode = CCG_PLL_OFF;
        end else if (s.sleep) begin
            n.mode = CCG_SLEEP;
        end else if (s.bypass) begin
            n.mode = CCG_ACTIVE; // [R11]
        end else begin
            n.mode = CCG_FULL_ON;
        end
        n.buf_out  = s.ref_s2 && s.buf_en; // [R1] [R2]
        n.core_out = core_div_clk;
        n.sys_out  = sys_div_clk;
        n.sys_pin  = sys_div_clk && s.sd_en && s.am_en; // [R8]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.pend_msel <= `CCG_MSEL_RESET;
            s.act_msel  <= `CCG_MSEL_RESET;
            s.ssel      <= `CCG_SSEL_RESET;
            s.csel      <= `CCG_CSEL_RESET;
            s.locked    <= 1'b1;
            s.buf_en    <= 1'b1;
            s.sd_en     <= 1'b1;
            s.am_en     <= 1'b1;
            s.mode      <= CCG_FULL_ON;
        end else begin
            s <= n;
        end
    end

    assign prdata               = s.prdata;
    assign pready               = s.pready;
    assign pslverr              = s.pslverr;
    assign buffered_clock_out   = s.buf_out;
    assign system_clock_out_pin = s.sys_pin;
    assign core_clock           = s.core_out;
    assign system_clock         = s.sys_out;
    assign pll_locked           = s.locked;
    assign op_mode              = s.mode;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_bufclk_copy: assert property ($past(s.buf_en) |-> buffered_clock_out == $past(s.ref_s2)) // [R1]
        else $error("buffered clock does not follow the reference");
    a_bufclk_stop: assert property (!s.buf_en [*2] |-> !buffered_clock_out) // [R2]
        else $error("buffered clock runs while disabled");
    a_mult_hold: assert property (s.lock_cnt == 16'h0 && !s.relock_req |=> $stable(s.act_msel)) // [R5]
        else $error("multiplier changed without the relock sequence");
    a_bypass_defer: assert property (s.bypass |=> $stable(s.act_msel) && $stable(s.act_df)) // [R10]
        else $error("multiplier changed while bypassed");
    a_div_onfly: assert property (psel && penable && pwrite && paddr == `CCG_OFF_CLK_DIV // [R6]
        && pwdata[5:4] != s.csel |=> s.csel == $past(pwdata[5:4]) && $stable(s.locked))
        else $error("divide write did not apply on the fly");
    a_ssel_zero: assert property (psel && penable && pwrite && paddr == `CCG_OFF_CLK_DIV // [R12]
        && pwdata[3:0] == 4'h0 |=> $stable(s.ssel))
        else $error("zero system select changed the ratio");
    a_ssel_floor: assert property (s.ssel >= SYS_RATIO_MIN) // [R7]
        else $error("system ratio below its limit");
    a_sleep_core: assert property (s.sleep [*3] |-> $stable(core_clock)) // [R11]
        else $error("core clock toggles in sleep");
    a_pin_disable: assert property (!(s.sd_en && s.am_en) |=> !system_clock_out_pin) // [R8]
        else $error("system clock pin driven while disabled");
    a_apb_error: assert property (psel && !penable |=> pslverr == !$past(addr_hit(paddr)))
        else $error("error answer does not match the address decode");

endmodule // ccg_clock_gen

// ### rtl/ccg_consts.svh
// Register offsets, field positions, reset values and counts of the clock generation block.
`ifndef CCG_CONSTS_SVH
`define CCG_CONSTS_SVH

`define CCG_OFF_PLL_CTRL     8'h00
`define CCG_OFF_CLK_DIV      8'h04
`define CCG_OFF_REG_CTRL     8'h08
`define CCG_OFF_SDRAM_GCTL   8'h0C
`define CCG_OFF_ASYNC_GCTL   8'h10
`define CCG_OFF_STATUS       8'h14

`define CCG_PLL_MSEL_LSB     0
`define CCG_PLL_DF_BIT       6
`define CCG_PLL_BYPASS_BIT   7
`define CCG_PLL_OFF_BIT      8
`define CCG_PLL_SLEEP_BIT    9
`define CCG_PLL_APPLY_BIT    10
`define CCG_DIV_SSEL_LSB     0
`define CCG_DIV_CSEL_LSB     4
`define CCG_ENABLE_BIT       0

`define CCG_MSEL_RESET       6'hA
`define CCG_SSEL_RESET       4'h5
`define CCG_CSEL_RESET       2'h0
`define CCG_LOCK_CYCLES      16'h0200
`define CCG_SYS_RATIO_MIN    4'h1
`define CCG_VCO_FULL         8'h80

`endif

// ### rtl/ccg_divider.sv
// Glitch-free clock divider: toggles its output every ratio ticks, new ratio taken at a toggle.
`timescale 1ns/1ps
`include "ccg_consts.svh"
module ccg_divider (
    input  wire logic       pclk,      // Block clock.
    input  wire logic       presetn,   // Asynchronous reset, active low.
    input  wire logic       tick,      // Source clock enable pulse.
    input  wire logic       run,       // Low freezes the output.
    input  wire logic [3:0] ratio,     // Ticks per half period, never zero.
    output logic            clk_out,   // Divided clock level.
    output logic            pulse      // One cycle at each output toggle.
);
    import ccg_pkg::*;

    ccg_div_s s, n;

    always_comb begin
        n = s;
        n.pulse = 1'b0;
        if (tick && run) begin
            if (s.cnt >= s.ratio - 4'h1) begin
                // The ratio is only swapped here, so no half period is ever cut short.
                n.cnt = 4'h0;
                n.ratio = ratio; // [R13]
                n.clk_out = ~s.clk_out;
                n.pulse = 1'b1;
            end else begin
                n.cnt = s.cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '{cnt: 4'h0, ratio: 4'h1, clk_out: 1'b0, pulse: 1'b0};
        end else begin
            s <= n;
        end
    end

    assign clk_out = s.clk_out;
    assign pulse   = s.pulse;

    a_div_boundary: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
        (s.ratio != $past(s.ratio)) |-> s.pulse)
        else $error("divider ratio changed away from a toggle");

endmodule // ccg_divider

// ### rtl/ccg_pkg.sv
// Types shared by the clock generation block and its divider.
package ccg_pkg;

    typedef enum logic [1:0] {
        CCG_FULL_ON = 2'b00,
        CCG_ACTIVE  = 2'b01,
        CCG_SLEEP   = 2'b10,
        CCG_PLL_OFF = 2'b11
    } ccg_mode_e;

    typedef struct packed {
        logic [3:0] cnt;
        logic [3:0] ratio;
        logic       clk_out;
        logic       pulse;
    } ccg_div_s;

    typedef struct packed {
        logic        ref_s1, ref_s2, ref_s3;
        logic        wake_s1, wake_s2, wake_s3;
        logic        pready, pslverr;
        logic [31:0] prdata;
        logic [5:0]  pend_msel;
        logic        pend_df;
        logic [5:0]  act_msel;
        logic        act_df;
        logic        bypass, pll_off, sleep, relock_req, locked;
        logic [15:0] lock_cnt;
        logic [6:0]  vco_acc;
        logic [3:0]  ssel;
        logic [1:0]  csel;
        logic        buf_en, sd_en, am_en;
        logic        buf_out, sys_pin, core_out, sys_out;
        ccg_mode_e   mode;
    } ccg_state_s;

endpackage
